// >>> davi_top.sv
// Delta angle and delta velocity integrator with read-only result registers
`timescale 1ns/10ps

// Overview of operation
// - Each axis delta velocity is the sum over one interval of each acceleration sample plus its predecessor, times 1/(2 fs).
// - Each axis delta angle uses the same trapezoidal sum on the angular rate samples.
// - One interval holds the decimation setting plus one pre-decimation samples.
// - Each result covers exactly one output update interval and a new value appears with every update.
// - With the internal sample clock the samples are taken at a nominal 2000 per second.
// - Each result is a 32-bit twos-complement value split into a 16-bit upper and a 16-bit lower register.
// - The lower delta angle word carries bits 15 to 0 below the upper word.
// - The upper delta angle word reads 0x0000 for zero and one code step is 2160 degrees over 2^15.
// - The delta angle code saturates at 0x7FFF positive and 0x8000 for minus 2160 degrees.
// - The lower delta velocity word carries 16 extra bits below the upper word.
// - The upper delta velocity word is twos complement over plus or minus 400 m/sec with 0x0000 for zero.
// - The y and z axes use the same accumulation, word split and scaling as the x axis.
module davi_top
	import davi_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES
)
(
	// Clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RST,
	// Pre-decimation sample stream from the sensor signal chains
	input  wire logic                SAMPLE_VALID,
	input  wire logic [SAMPLE_W-1:0] X_RATE,
	input  wire logic [SAMPLE_W-1:0] Y_RATE,
	input  wire logic [SAMPLE_W-1:0] Z_RATE,
	input  wire logic [SAMPLE_W-1:0] X_ACCEL,
	input  wire logic [SAMPLE_W-1:0] Y_ACCEL,
	input  wire logic [SAMPLE_W-1:0] Z_ACCEL,
	// Decimation setting from the configuration logic
	input  wire logic [DEC_W-1:0]    DECIMATION_SETTING,
	// Register read port
	input  wire logic                REG_READ,
	input  wire logic [ADDR_W-1:0]   REG_ADDR,
	output logic      [DATA_W-1:0]   REG_RDATA,
	output logic                     REG_RVALID,
	// Internal sample clock and output update marker
	output logic                     SAMPLE_TICK,
	output logic                     UPDATE_STROBE
);

	// Sequencer state
	davi_state_type      state;
	davi_state_type      next_state;
	logic [DEC_W-1:0]    sample_count;
	logic [DEC_W-1:0]    next_sample_count;
	logic [DEC_W-1:0]    dec_held;
	logic [DEC_W-1:0]    next_dec_held;
	logic                next_update_strobe;

	// Internal sample clock state
	logic [TICK_W-1:0]   tick_count;
	logic [TICK_W-1:0]   next_tick_count;
	logic                next_sample_tick;

	// Read port state
	logic [DATA_W-1:0]   next_rdata;
	logic                next_rvalid;

	// Channel wiring: indices 0..2 angle x,y,z, 3..5 velocity x,y,z
	logic [SAMPLE_W-1:0] chan_sample [0:CHANNELS-1];
	logic [RESULT_W-1:0] chan_result [0:CHANNELS-1];
	logic                accumulate_en;
	logic                close_interval;

	// Sample period counter value at which the tick fires, cut to the counter width
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_PERIOD - 1);

	// Pick the upper or lower word of a 32-bit result
	function automatic logic [DATA_W-1:0] word_of(input logic [RESULT_W-1:0] value, input logic upper);
		if (upper) begin
			return value[RESULT_W-1:DATA_W];
		end
		return value[DATA_W-1:0];
	endfunction : word_of

	// Map a register address to its result word; unmapped addresses read zero
	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0]   addr,
		input logic [RESULT_W-1:0] r0,
		input logic [RESULT_W-1:0] r1,
		input logic [RESULT_W-1:0] r2,
		input logic [RESULT_W-1:0] r3,
		input logic [RESULT_W-1:0] r4,
		input logic [RESULT_W-1:0] r5
	);
		logic [ADDR_W-1:0] word_addr;
		word_addr = {addr[ADDR_W-1:1], 1'b0};
		case (word_addr)
			X_ANGLE_DELTA_LOW_WORD_ADDR:     return word_of(r0, 1'b0);
			X_ANGLE_DELTA_HIGH_WORD_ADDR:    return word_of(r0, 1'b1);
			Y_ANGLE_DELTA_LOW_WORD_ADDR:     return word_of(r1, 1'b0);
			Y_ANGLE_DELTA_HIGH_WORD_ADDR:    return word_of(r1, 1'b1);
			Z_ANGLE_DELTA_LOW_WORD_ADDR:     return word_of(r2, 1'b0);
			Z_ANGLE_DELTA_HIGH_WORD_ADDR:    return word_of(r2, 1'b1);
			X_VELOCITY_DELTA_LOW_WORD_ADDR:  return word_of(r3, 1'b0);
			X_VELOCITY_DELTA_HIGH_WORD_ADDR: return word_of(r3, 1'b1);
			Y_VELOCITY_DELTA_LOW_WORD_ADDR:  return word_of(r4, 1'b0);
			Y_VELOCITY_DELTA_HIGH_WORD_ADDR: return word_of(r4, 1'b1);
			Z_VELOCITY_DELTA_LOW_WORD_ADDR:  return word_of(r5, 1'b0);
			Z_VELOCITY_DELTA_HIGH_WORD_ADDR: return word_of(r5, 1'b1);
			default:                         return READ_ZERO;
		endcase
	endfunction : read_word

	// Route the six input streams onto the channel array
	always_comb begin
		chan_sample[0] = X_RATE;
		chan_sample[1] = Y_RATE;
		chan_sample[2] = Z_RATE;
		chan_sample[3] = X_ACCEL;
		chan_sample[4] = Y_ACCEL;
		chan_sample[5] = Z_ACCEL;
	end

	// Interval control shared by all channels, so every result closes on the same sample
	always_comb begin
		accumulate_en  = (state == ST_RUN);
		close_interval = (state == ST_RUN) && (sample_count == dec_held);
	end

	// Six identical accumulators; identical hardware keeps the axes consistent
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		davi_axis u_axis (
			.clk            (SYS_CLK),
			.rst            (RST),
			.sample_valid   (SAMPLE_VALID),
			.accumulate_en  (accumulate_en),
			.close_interval (close_interval),
			.sample         (chan_sample[ch]),
			.result         (chan_result[ch])
		);
	end

	// Sequencer: the first sample after reset only primes the predecessor register,
	// since a trapezoid needs two points and no earlier sample exists
	always_comb begin
		next_state         = state;
		next_sample_count  = sample_count;
		next_dec_held      = dec_held;
		next_update_strobe = 1'b0;
		case (state)
			ST_PRIME: begin
				if (SAMPLE_VALID) begin
					next_state        = ST_RUN;
					next_sample_count = DEC_RESET;
					next_dec_held     = DECIMATION_SETTING;
				end
			end
			ST_RUN: begin
				if (SAMPLE_VALID) begin
					if (close_interval) begin
						// Setting is taken only at an interval boundary so a change never splits one
						next_sample_count  = DEC_RESET;
						next_dec_held      = DECIMATION_SETTING;
						next_update_strobe = 1'b1;
					end else begin
						next_sample_count  = sample_count + COUNT_ONE;
					end
				end
			end
			default: begin
				next_state        = ST_PRIME;
				next_sample_count = DEC_RESET;
				next_dec_held     = DEC_RESET;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state         <= ST_PRIME;
			sample_count  <= DEC_RESET;
			dec_held      <= DEC_RESET;
			UPDATE_STROBE <= 1'b0;
		end else begin
			state         <= next_state;
			sample_count  <= next_sample_count;
			dec_held      <= next_dec_held;
			UPDATE_STROBE <= next_update_strobe;
		end
	end

	// Internal sample clock: one tick every nominal sample period
	always_comb begin
		next_sample_tick = 1'b0;
		if (tick_count == TICK_LAST) begin
			next_tick_count  = TICK_RESET;
			next_sample_tick = 1'b1;
		end else begin
			next_tick_count  = tick_count + TICK_ONE;
		end
	end

	// Sample clock registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tick_count  <= TICK_RESET;
			SAMPLE_TICK <= 1'b0;
		end else begin
			tick_count  <= next_tick_count;
			SAMPLE_TICK <= next_sample_tick;
		end
	end

	// Read port: data is sampled from the held results, which change only as whole 32-bit
	// words, but each half is read on its own, so an update between two reads can mix two intervals
	always_comb begin
		next_rvalid = REG_READ;
		next_rdata  = REG_RDATA;
		if (REG_READ) begin
			next_rdata = read_word(REG_ADDR, chan_result[0], chan_result[1], chan_result[2],
			                       chan_result[3], chan_result[4], chan_result[5]);
		end
	end

	// Read port registers
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			REG_RDATA  <= READ_ZERO;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA  <= next_rdata;
			REG_RVALID <= next_rvalid;
		end
	end

endmodule : davi_top

// >>> davi_pkg.sv
// Constants, register map and types shared by the delta angle and delta velocity integrator
package davi_pkg;

	// Data path widths
	localparam int DATA_W   = 16;
	localparam int ADDR_W   = 7;
	localparam int SAMPLE_W = 32;
	localparam int RESULT_W = 32;
	localparam int ACC_W    = 44;
	localparam int DEC_W    = 11;
	localparam int TICK_W   = 16;
	localparam int CHANNELS = 6;

	// Register byte addresses, one 16-bit word each
	localparam logic [ADDR_W-1:0] X_ANGLE_DELTA_LOW_WORD_ADDR     = 7'h24;
	localparam logic [ADDR_W-1:0] X_ANGLE_DELTA_HIGH_WORD_ADDR    = 7'h26;
	localparam logic [ADDR_W-1:0] Y_ANGLE_DELTA_LOW_WORD_ADDR     = 7'h28;
	localparam logic [ADDR_W-1:0] Y_ANGLE_DELTA_HIGH_WORD_ADDR    = 7'h2A;
	localparam logic [ADDR_W-1:0] Z_ANGLE_DELTA_LOW_WORD_ADDR     = 7'h2C;
	localparam logic [ADDR_W-1:0] Z_ANGLE_DELTA_HIGH_WORD_ADDR    = 7'h2E;
	localparam logic [ADDR_W-1:0] X_VELOCITY_DELTA_LOW_WORD_ADDR  = 7'h30;
	localparam logic [ADDR_W-1:0] X_VELOCITY_DELTA_HIGH_WORD_ADDR = 7'h32;
	localparam logic [ADDR_W-1:0] Y_VELOCITY_DELTA_LOW_WORD_ADDR  = 7'h34;
	localparam logic [ADDR_W-1:0] Y_VELOCITY_DELTA_HIGH_WORD_ADDR = 7'h36;
	localparam logic [ADDR_W-1:0] Z_VELOCITY_DELTA_LOW_WORD_ADDR  = 7'h38;
	localparam logic [ADDR_W-1:0] Z_VELOCITY_DELTA_HIGH_WORD_ADDR = 7'h3A;

	// Reset values and fixed codes
	localparam logic [RESULT_W-1:0] RESULT_RESET   = 32'h0000_0000;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET   = 32'h0000_0000;
	localparam logic [ACC_W-1:0]    ACC_RESET      = 44'h000_0000_0000;
	localparam logic [DATA_W-1:0]   READ_ZERO      = 16'h0000;
	localparam logic [DEC_W-1:0]    DEC_RESET      = 11'h000;
	localparam logic [DEC_W-1:0]    COUNT_ONE      = 11'h001;
	localparam logic [TICK_W-1:0]   TICK_RESET     = 16'h0000;
	localparam logic [TICK_W-1:0]   TICK_ONE       = 16'h0001;
	localparam logic [RESULT_W-1:0] SAT_POS        = 32'h7FFF_FFFF;
	localparam logic [RESULT_W-1:0] SAT_NEG        = 32'h8000_0000;
	localparam logic [ACC_W-1:0]    SAT_POS_WIDE   = 44'h000_7FFF_FFFF;
	localparam logic [ACC_W-1:0]    SAT_NEG_WIDE   = 44'hFFF_8000_0000;

	// Timing: nominal internal sample rate and the clock it is derived from
	localparam int CLK_PERIOD_NS        = 25;
	localparam int NOMINAL_RATE_SPS     = 2000;
	localparam int SAMPLE_PERIOD_NS     = 1000000000 / NOMINAL_RATE_SPS;
	localparam int SAMPLE_PERIOD_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	// Sequencer states
	typedef enum logic [0:0] {
		ST_PRIME = 1'b0,
		ST_RUN   = 1'b1
	} davi_state_type;

endpackage : davi_pkg

// >>> davi_axis.sv
// One channel of trapezoidal accumulation with saturating 32-bit result
`timescale 1ns/10ps

module davi_axis
	import davi_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Sample stream and interval control
	input  wire logic                sample_valid,
	input  wire logic                accumulate_en,
	input  wire logic                close_interval,
	input  wire logic [SAMPLE_W-1:0] sample,
	// Held result of the last closed interval
	output logic      [RESULT_W-1:0] result
);

	logic [SAMPLE_W-1:0] prev;
	logic [ACC_W-1:0]    acc;
	logic [SAMPLE_W-1:0] next_prev;
	logic [ACC_W-1:0]    next_acc;
	logic [RESULT_W-1:0] next_result;
	logic [ACC_W-1:0]    pair;
	logic [ACC_W-1:0]    sum;

	// Clamp the wide sum into the 32-bit twos-complement code range
	function automatic logic [RESULT_W-1:0] saturate(input logic [ACC_W-1:0] v);
		if ($signed(v) > $signed(SAT_POS_WIDE)) begin
			return SAT_POS;
		end else if ($signed(v) < $signed(SAT_NEG_WIDE)) begin
			return SAT_NEG;
		end
		return v[RESULT_W-1:0];
	endfunction : saturate

	// Sign-extended pair sum cannot overflow, so no intermediate clamp is needed
	always_comb begin
		pair        = {{(ACC_W-SAMPLE_W){sample[SAMPLE_W-1]}}, sample}
		            + {{(ACC_W-SAMPLE_W){prev[SAMPLE_W-1]}}, prev};
		sum         = acc + pair;
		next_prev   = prev;
		next_acc    = acc;
		next_result = result;
		if (sample_valid) begin
			next_prev = sample;
			if (accumulate_en) begin
				if (close_interval) begin
					next_result = saturate(sum);
					next_acc    = ACC_RESET;
				end else begin
					next_acc    = sum;
				end
			end
		end
	end

	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			prev   <= SAMPLE_RESET;
			acc    <= ACC_RESET;
			result <= RESULT_RESET;
		end else begin
			prev   <= next_prev;
			acc    <= next_acc;
			result <= next_result;
		end
	end

endmodule : davi_axis

// >>> davi_top_assertions.sv
// Port-level checks of the delta angle and delta velocity integrator
`timescale 1ns/10ps

module davi_top_assertions
	import davi_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_PERIOD_CYCLES
)
(
	// Clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RST,
	// Sample stream and update marker
	input wire logic              SAMPLE_VALID,
	input wire logic              SAMPLE_TICK,
	input wire logic              UPDATE_STROBE,
	// Register read port
	input wire logic              REG_READ,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic              REG_RVALID
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	logic [TICK_W-1:0] gap;
	logic              seen;
	logic [TICK_W-1:0] next_gap;
	logic              next_seen;

	// Cycles since the last tick; the first tick only arms the check, its gap from reset reads one more than the spacing
	always_comb begin
		next_gap  = SAMPLE_TICK ? TICK_RESET : gap + TICK_ONE;
		next_seen = seen | SAMPLE_TICK;
	end
	always_ff @(posedge SYS_CLK) begin
		gap  <= RST ? TICK_RESET : next_gap;
		seen <= RST ? 1'b0 : next_seen;
	end

	chk_read_answer: assert property (REG_READ |=> REG_RVALID) else $error("read got no answer");
	chk_no_stray: assert property (!REG_READ |=> !REG_RVALID) else $error("answer without read");
	chk_unmapped_zero: assert property (REG_READ && (REG_ADDR < 7'h24 || REG_ADDR > 7'h3B) |=>
		REG_RDATA == READ_ZERO) else $error("unmapped word not zero");
	chk_data_holds: assert property (!REG_RVALID |-> $stable(REG_RDATA)) else $error("read data moved idle");
	chk_result_stable: assert property (REG_READ && $past(REG_READ) && $stable(REG_ADDR) && !UPDATE_STROBE
		|=> $stable(REG_RDATA)) else $error("result changed without update");
	chk_strobe_cause: assert property (UPDATE_STROBE |-> $past(SAMPLE_VALID)) else $error("update without sample");
	chk_reset_quiet: assert property (@(posedge SYS_CLK) disable iff (1'b0) RST |=>
		!UPDATE_STROBE && !REG_RVALID && !SAMPLE_TICK) else $error("output active in reset");
	chk_tick_spacing: assert property (SAMPLE_TICK && seen |-> gap == SAMPLE_PERIOD - 1)
		else $error("tick spacing wrong");
	chk_tick_missed: assert property (seen |-> gap < SAMPLE_PERIOD) else $error("tick missing");

	cov_update: cover property (UPDATE_STROBE);
	cov_read_pair: cover property (REG_READ ##1 REG_READ);
	cov_tick: cover property (SAMPLE_TICK && seen);
endmodule : davi_top_assertions

bind davi_top davi_top_assertions #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) davi_top_assertions_i (
	.SYS_CLK(SYS_CLK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_TICK(SAMPLE_TICK),
	.UPDATE_STROBE(UPDATE_STROBE), .REG_READ(REG_READ), .REG_ADDR(REG_ADDR),
	.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));

// >>> davi_host_model.sv
// Host model that reads result words over the register read port
`timescale 1ns/10ps

module davi_host_model
	import davi_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Answer from the block
	input  wire logic [DATA_W-1:0] rdata,
	input  wire logic              rvalid,
	// Request to the block
	output logic                   read,
	output logic      [ADDR_W-1:0] addr
);
	initial begin
		read = 1'b0;
		addr = 7'h00;
	end

	// Request held n cycles; the released address is scrambled so nothing leans on it
	task automatic read_word(input logic [ADDR_W-1:0] a, input int n, output logic [DATA_W-1:0] d, output logic ok);
		@(posedge clk);
		read <= 1'b1;
		addr <= a;
		repeat (n) @(posedge clk);
		read <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		ok = rvalid;
		d = rdata;
	endtask : read_word
endmodule : davi_host_model

// >>> davi_tb_top.sv
// Self-checking testbench of the delta angle and delta velocity integrator
`timescale 1ns/10ps
`define CMP(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected %s: expected %h seen %h", what, exp, got); end end

module davi_tb_top;
	import davi_pkg::*;
	localparam int PERIOD = 8;
	logic                sys_clk, rst, sample_valid, reg_read, reg_rvalid, sample_tick, update_strobe;
	logic [SAMPLE_W-1:0] chan [6];
	logic [SAMPLE_W-1:0] prev [6];
	longint              acc [6];
	logic [DEC_W-1:0]    decimation;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_rdata;
	int                  miscompares, samples_checked, strobes;
	bit                  primed;

	davi_top #(.SAMPLE_PERIOD(PERIOD)) davi_top_i (.SYS_CLK(sys_clk), .RST(rst), .SAMPLE_VALID(sample_valid),
		.X_RATE(chan[0]), .Y_RATE(chan[1]), .Z_RATE(chan[2]), .X_ACCEL(chan[3]), .Y_ACCEL(chan[4]),
		.Z_ACCEL(chan[5]), .DECIMATION_SETTING(decimation), .REG_READ(reg_read), .REG_ADDR(reg_addr),
		.REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .SAMPLE_TICK(sample_tick), .UPDATE_STROBE(update_strobe));
	davi_host_model davi_host_i (.clk(sys_clk), .rdata(reg_rdata), .rvalid(reg_rvalid), .read(reg_read),
		.addr(reg_addr));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Counted on the falling edge so no race with the tasks at the rising one
	always @(negedge sys_clk) if (update_strobe === 1'b1) strobes++;

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	// Reset with the setting already in place, and clear the model
	task automatic restart(input logic [DEC_W-1:0] setting);
		@(posedge sys_clk);
		rst <= 1'b1;
		decimation <= setting;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		primed = 1'b0;
		strobes = 0;
		foreach (acc[c]) begin acc[c] = 0; prev[c] = SAMPLE_RESET; end
	endtask : restart

	// One sample on all six channels, each axis offset so the channels differ
	task automatic put(input logic [SAMPLE_W-1:0] v, input logic [SAMPLE_W-1:0] w);
		logic [SAMPLE_W-1:0] cur;
		@(posedge sys_clk);
		for (int c = 0; c < 6; c++) begin
			cur = (c < 3 ? v : w) + 32'(c % 3);
			chan[c] <= cur;
			if (primed) acc[c] += longint'(signed'(cur)) + longint'(signed'(prev[c]));
			prev[c] = cur;
		end
		primed = 1'b1;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
	endtask : put

	// Reads both words of every result between updates, then opens a new interval in the model
	task automatic check_all(input int exp_strobes);
		logic [DATA_W-1:0]   d;
		logic [RESULT_W-1:0] e;
		logic                ok;
		repeat (3) @(posedge sys_clk);
		`CMP("update count", exp_strobes, strobes)
		for (int c = 0; c < 6; c++) begin
			e = acc[c] > 64'sh7FFF_FFFF ? SAT_POS : (acc[c] < -64'sh8000_0000 ? SAT_NEG : acc[c][31:0]);
			// Held for two reads of one word, so the checker sees repeated reads of a live result
			davi_host_i.read_word(7'h26 + 7'(4 * c), 2, d, ok);
			`CMP("high word", e[31:16], d)
			davi_host_i.read_word(7'h24 + 7'(4 * c), 1, d, ok);
			`CMP("low word", e[15:0], d)
			`CMP("read answer", 1'b1, ok)
			acc[c] = 0;
		end
		strobes = 0;
	endtask : check_all

	task automatic sc_reset_read();
		logic [DATA_W-1:0] d;
		logic              ok;
		restart(11'h000);
		check_all(0);
		davi_host_i.read_word(7'h3C, 2, d, ok);
		`CMP("unmapped word", READ_ZERO, d)
		davi_host_i.read_word(7'h22, 2, d, ok);
		`CMP("unmapped word", READ_ZERO, d)
	endtask : sc_reset_read

	// Two samples per result; the predecessor carries into the next interval
	task automatic sc_trapezoid();
		restart(11'h001);
		put(32'h0001_2345, 32'hFFFF_FF00);
		put(32'h0000_0010, 32'h0002_0000);
		put(32'hFFFF_0001, 32'h0000_0003);
		check_all(1);
		put(32'h0123_4567, 32'hFEDC_BA98);
		put(32'h0000_0001, 32'h8000_0001);
		check_all(1);
	endtask : sc_trapezoid

	// One sample per result at the smallest setting, then both saturation limits
	task automatic sc_single_sat();
		restart(11'h000);
		put(32'h0000_0100, 32'hFFFF_0000);
		for (int i = 1; i < 4; i++) begin
			put(32'(i) * 32'h0010_0000, 32'hFFFF_FFF0 - 32'(i));
			check_all(1);
		end
		// Each saturating interval is read on its own, since only the last result is held
		for (int i = 0; i < 2; i++) begin
			put(32'h7FFF_0000, 32'h8000_0000);
			check_all(1);
		end
	endtask : sc_single_sat

	// Largest setting: no update before the last of 2048 samples
	task automatic sc_longest();
		restart(11'h7FF);
		repeat (2048) put(32'h0000_0001, 32'hFFFF_FFFF);
		repeat (3) @(posedge sys_clk);
		`CMP("early update", 0, strobes)
		put(32'h0000_0001, 32'hFFFF_FFFF);
		check_all(1);
	endtask : sc_longest

	// Measures the tick spacing of the shortened test period at decimation zero, then checks the nominal period constant
	task automatic sc_tick();
		int n;
		restart(11'h000);
		for (n = 0; n < 100 && sample_tick !== 1'b1; n++) @(posedge sys_clk);
		if (n >= 100) miscompares++;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (sample_tick !== 1'b1 && n < 100);
		if (n >= 100) miscompares++;
		`CMP("tick spacing", PERIOD, n)
		`CMP("nominal period", 40_000_000 / 2000, SAMPLE_PERIOD_CYCLES)
	endtask : sc_tick

	initial begin
		rst = 1'b1;
		sample_valid = 1'b0;
		decimation = DEC_RESET;
		foreach (chan[c]) chan[c] = SAMPLE_RESET;
		miscompares = 0;
		samples_checked = 0;
		sc_reset_read();
		sc_trapezoid();
		sc_single_sat();
		sc_longest();
		sc_tick();
		end_of_test();
	end
endmodule : davi_tb_top
